/* File: src/prntv_top.sv */
// test stream generator with output buffer, plus received stream checker
`timescale 1ns/1ps
`include "prntv_params.svh"
module prntv_top (
    // clock and reset
    input  wire logic                       REF_CLK,
    input  wire logic                       RST,
    // generator control
    input  wire logic                       GEN_ENABLE,
    input  wire logic [1:0]                 GEN_MODE,
    input  wire logic [`PRNTV_RATE_W-1:0]   RATE_LOG2,
    input  wire logic                       REPLAY_SECOND_TICK,
    // generated streams
    input  wire logic                       TX_READY,
    output logic      [`PRNTV_STREAMS-1:0]  TEST_STREAMS,
    output logic                            TX_VALID,
    output logic                            TX_FIRST,
    // checker input
    input  wire logic                       ACQUIRE_SECOND_TICK,
    input  wire logic [`PRNTV_STREAMS-1:0]  RX_STREAMS,
    input  wire logic                       RX_VALID,
    // checker readout
    input  wire logic [`PRNTV_SEL_W-1:0]    ERR_SEL,
    output logic      [`PRNTV_CNT_W-1:0]    ERR_COUNT,
    output logic      [`PRNTV_CNT_W-1:0]    BITS_CHECKED,
    output logic                            CHECK_ARMED
);
    prntv_pkg::prntv_state_type    state_q;
    prntv_pkg::prntv_state_type    state_d;
    prntv_pkg::prntv_mode_type     mode;
    prntv_pkg::prntv_lfsr_type     lfsr_q [`PRNTV_STREAMS];
    prntv_pkg::prntv_beat_type     gen_beat;
    prntv_pkg::prntv_beat_type     out_q;
    prntv_pkg::prntv_beat_type     skid_q;
    logic                          skid_v_q;
    logic                          tick_q;
    logic                          tick_edge;
    logic [`PRNTV_DIV_W-1:0]       div_q;
    logic [`PRNTV_DIV_W-1:0]       div_last;
    logic                          bit_en;
    logic                          pend_q;
    logic                          first_q;
    logic                          push;
    logic                          pop;
    logic                          gen_ready;
    logic [`PRNTV_STEP_W-1:0]      step_q;

    assign mode      = prntv_pkg::prntv_mode_type'(GEN_MODE);
    assign tick_edge = REPLAY_SECOND_TICK & ~tick_q;
    assign div_last  = (`PRNTV_DIV_W'(1) << RATE_LOG2) - 1'b1;
    assign bit_en    = (state_q == prntv_pkg::ST_RUN) && div_q == div_last;
    assign gen_ready = ~skid_v_q;
    assign push      = pend_q & gen_ready;
    assign pop       = TX_VALID & TX_READY;

    // output bit of one lane for the selected mode
    function automatic logic lane_bit(prntv_pkg::prntv_mode_type m,
                                      logic                      msb);
        case (m)
            prntv_pkg::MODE_ZEROS: return 1'b0;
            prntv_pkg::MODE_ONES:  return 1'b1;
            default:               return msb;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            prntv_pkg::ST_IDLE: begin
                if (GEN_ENABLE) begin
                    state_d = prntv_pkg::ST_WAIT;
                end
            end
            prntv_pkg::ST_WAIT: begin
                if (!GEN_ENABLE) begin
                    state_d = prntv_pkg::ST_IDLE;
                end else if (tick_edge) begin
                    state_d = prntv_pkg::ST_RUN;
                end
            end
            prntv_pkg::ST_RUN: begin
                if (!GEN_ENABLE) begin
                    state_d = prntv_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = prntv_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= prntv_pkg::ST_IDLE;
            tick_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            tick_q  <= REPLAY_SECOND_TICK;
        end
    end

    // ---------------------------------------------------------------
    // bit rate divider, aligned to the tick
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_q <= '0;
        end else if (tick_edge || state_q != prntv_pkg::ST_RUN) begin
            div_q <= '0;
        end else if (bit_en) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // one pending bit time; generator stalls while buffer is full
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pend_q  <= 1'b0;
            first_q <= 1'b0;
        end else if (tick_edge || state_q != prntv_pkg::ST_RUN) begin
            pend_q  <= 1'b0;
            first_q <= 1'b1;
        end else begin
            pend_q  <= bit_en | (pend_q & ~push);
            if (push) begin
                first_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // one register per stream
    // ---------------------------------------------------------------
    for (genvar i = 0; i < `PRNTV_STREAMS; i++) begin : g_lane
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                lfsr_q[i] <= prntv_pkg::seed_of(i);
            end else if (tick_edge) begin
                lfsr_q[i] <= prntv_pkg::seed_of(i);
            end else if (push) begin
                lfsr_q[i] <= prntv_pkg::lfsr_step(lfsr_q[i]);
            end
        end
        assign gen_beat.bits[i] = lane_bit(mode, lfsr_q[i][14]);
    end
    assign gen_beat.first = first_q;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            step_q <= '0;
        end else if (tick_edge) begin
            step_q <= '0;
        end else if (push) begin
            // the push at the period end leaves the seed again
            step_q <= (step_q == `PRNTV_PERIOD) ? `PRNTV_STEP_W'(1)
                                                : step_q + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // two-entry buffer: output register plus skid register
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            skid_v_q <= 1'b0;
            skid_q   <= '0;
        end else if (push && TX_VALID && !TX_READY) begin
            skid_v_q <= 1'b1;
            skid_q   <= gen_beat;
        end else if (TX_READY) begin
            skid_v_q <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            out_q    <= '1;
            TX_VALID <= 1'b0;
        end else if (!TX_VALID || TX_READY) begin
            if (skid_v_q) begin
                out_q    <= skid_q;
                TX_VALID <= 1'b1;
            end else if (push) begin
                out_q    <= gen_beat;
                TX_VALID <= 1'b1;
            end else begin
                out_q    <= '1;
                TX_VALID <= 1'b0;
            end
        end
    end
    assign TEST_STREAMS = out_q.bits;
    assign TX_FIRST     = out_q.first;

    // ---------------------------------------------------------------
    // checker
    // ---------------------------------------------------------------
    prntv_checker u_checker (
        .clk          (REF_CLK),
        .rst          (RST),
        .tick         (ACQUIRE_SECOND_TICK),
        .rx_bits      (RX_STREAMS),
        .rx_valid     (RX_VALID),
        .err_sel      (ERR_SEL),
        .err_count    (ERR_COUNT),
        .bits_checked (BITS_CHECKED),
        .armed        (CHECK_ARMED)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_tick_reseed: assert property (@(posedge REF_CLK)
        disable iff (RST)
        tick_edge |=> lfsr_q[0] == prntv_pkg::seed_of(0)
        && lfsr_q[31] == prntv_pkg::seed_of(31) && step_q == 0)
        else $error("streams not restarted on tick");
    chk_period_wrap: assert property (@(posedge REF_CLK)
        disable iff (RST)
        step_q == `PRNTV_PERIOD |-> lfsr_q[5] == prntv_pkg::seed_of(5))
        else $error("stream period is not 32767");
    chk_idle_ones: assert property (@(posedge REF_CLK)
        disable iff (RST)
        !TX_VALID |-> TEST_STREAMS == '1)
        else $error("idle outputs not held high");
    chk_fixed_zero: assert property (@(posedge REF_CLK)
        disable iff (RST)
        push && mode == prntv_pkg::MODE_ZEROS && !TX_VALID
        |=> TX_VALID && TEST_STREAMS == '0)
        else $error("zero mode did not drive zeros");
    chk_prn_lanes: assert property (@(posedge REF_CLK)
        disable iff (RST)
        push && mode == prntv_pkg::MODE_PRN && !TX_VALID
        |=> TEST_STREAMS[7] == $past(lfsr_q[7][14])
        && TEST_STREAMS[30] == $past(lfsr_q[30][14]))
        else $error("stream lane not from its register");
    chk_rate_two: assert property (@(posedge REF_CLK)
        disable iff (RST)
        bit_en && RATE_LOG2 == 3'h1 && GEN_ENABLE
        ##1 !REPLAY_SECOND_TICK && GEN_ENABLE && RATE_LOG2 == 3'h1
        |-> !bit_en ##1 (bit_en || RATE_LOG2 != 3'h1))
        else $error("bit rate not clock over two");
    chk_hold_stall: assert property (@(posedge REF_CLK)
        disable iff (RST)
        TX_VALID && !TX_READY |=> TX_VALID
        && TEST_STREAMS == $past(TEST_STREAMS))
        else $error("stalled word changed");
    chk_full_stalls: assert property (@(posedge REF_CLK) disable iff (RST)
        skid_v_q && !TX_READY |=> skid_v_q && skid_q == $past(skid_q))
        else $error("buffer entry lost under stall");

    cov_prn_run: cover property (@(posedge REF_CLK) disable iff (RST)
        pop && TX_FIRST && mode == prntv_pkg::MODE_PRN);
    cov_ones_mode: cover property (@(posedge REF_CLK) disable iff (RST)
        pop && mode == prntv_pkg::MODE_ONES);
    cov_buffer_full: cover property (@(posedge REF_CLK) disable iff (RST)
        skid_v_q && pend_q);
    cov_period_wrap: cover property (@(posedge REF_CLK) disable iff (RST)
        step_q == `PRNTV_PERIOD);
endmodule

/* File: src/prntv_params.svh */
// constants for the pseudo-random test stream generator and checker
// Functional notes
// - The generator drives 32 distinct pseudo-random streams at once.
// - Each stream repeats every 32767 bits, from a 15-stage register.
// - Every second tick restarts all streams together from their seeds.
// - Streams advance at the bit rate of the data stream they replace.
// - The input side has a checker that validates received streams.
// - The output side has a generator for the far receiver to validate.
// - Any output not in active use is held at logic one.
// - A fixed mode drives all zeros or all ones on all 32 outputs.
// - A constant input gives the checker an error rate near one half.
`ifndef PRNTV_PARAMS_SVH
`define PRNTV_PARAMS_SVH

// ---------------------------------------------------------------
// stream shape
// ---------------------------------------------------------------
`define PRNTV_STREAMS    32
`define PRNTV_SEL_W      5
`define PRNTV_LFSR_W     15
`define PRNTV_PERIOD     16'h7fff
`define PRNTV_SEED_LOW   10'h2a5

// ---------------------------------------------------------------
// rate divider and counters
// ---------------------------------------------------------------
`define PRNTV_RATE_W     3
`define PRNTV_DIV_W      8
`define PRNTV_CNT_W      32
`define PRNTV_STEP_W     16

`endif

/* File: src/prntv_pkg.sv */
// types and shared stream functions for the test stream block
`include "prntv_params.svh"
package prntv_pkg;

    // ---------------------------------------------------------------
    // modes, states, carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PRN   = 2'h0,
        MODE_ZEROS = 2'h1,
        MODE_ONES  = 2'h3
    } prntv_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_RUN  = 2'h3
    } prntv_state_type;

    typedef logic [`PRNTV_LFSR_W-1:0] prntv_lfsr_type;

    typedef struct packed {
        logic                      first;
        logic [`PRNTV_STREAMS-1:0] bits;
    } prntv_beat_type;

    // ---------------------------------------------------------------
    // x^15 + x^14 + 1, maximal length
    // ---------------------------------------------------------------
    function automatic prntv_lfsr_type lfsr_step(prntv_lfsr_type s);
        return {s[13:0], s[14] ^ s[13]};
    endfunction

    // distinct non-zero seed per stream
    function automatic prntv_lfsr_type seed_of(int idx);
        logic [4:0] hi;
        hi = 5'(idx);
        return {hi, `PRNTV_SEED_LOW};
    endfunction

endpackage

/* File: src/prntv_checker.sv */
// received test stream checker with per-stream mismatch counters
`timescale 1ns/1ps
`include "prntv_params.svh"
module prntv_checker (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // received streams
    input  wire logic                       tick,
    input  wire logic [`PRNTV_STREAMS-1:0]  rx_bits,
    input  wire logic                       rx_valid,
    // readout
    input  wire logic [`PRNTV_SEL_W-1:0]    err_sel,
    output logic      [`PRNTV_CNT_W-1:0]    err_count,
    output logic      [`PRNTV_CNT_W-1:0]    bits_checked,
    output logic                            armed
);
    logic                        tick_q;
    logic                        tick_edge;
    prntv_pkg::prntv_lfsr_type   rep_q [`PRNTV_STREAMS];
    logic [`PRNTV_CNT_W-1:0]     err_q [`PRNTV_STREAMS];

    assign tick_edge = tick & ~tick_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
        end
    end

    // ---------------------------------------------------------------
    // replica and counters per stream
    // ---------------------------------------------------------------
    for (genvar i = 0; i < `PRNTV_STREAMS; i++) begin : g_lane
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                rep_q[i] <= prntv_pkg::seed_of(i);
            end else if (tick_edge) begin
                rep_q[i] <= prntv_pkg::seed_of(i);
            end else if (rx_valid && armed) begin
                rep_q[i] <= prntv_pkg::lfsr_step(rep_q[i]);
            end
        end
        // constant input still mismatches half the replica bits
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                err_q[i] <= '0;
            end else if (tick_edge) begin
                err_q[i] <= '0;
            end else if (rx_valid && armed
                         && rx_bits[i] != rep_q[i][14]) begin
                err_q[i] <= err_q[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed        <= 1'b0;
            bits_checked <= '0;
        end else if (tick_edge) begin
            armed        <= 1'b1;
            bits_checked <= '0;
        end else if (rx_valid && armed) begin
            bits_checked <= bits_checked + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_count <= '0;
        end else begin
            err_count <= err_q[err_sel];
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_count_mismatch: assert property (@(posedge clk)
        disable iff (rst)
        armed && rx_valid && !tick_edge && rx_bits[0] != rep_q[0][14]
        |=> err_q[0] == $past(err_q[0]) + 1)
        else $error("mismatch on stream 0 not counted");
    chk_replica_reseed: assert property (@(posedge clk)
        disable iff (rst)
        tick_edge |=> rep_q[3] == prntv_pkg::seed_of(3) && err_q[3] == 0
        && armed)
        else $error("checker not restarted on tick");
    cov_mismatch: cover property (@(posedge clk) disable iff (rst)
        armed && rx_valid && rx_bits[0] != rep_q[0][14]);
endmodule

/* File: tb/prntv_sink.sv */
// processing equipment model: accepts test words, stalls when told
`timescale 1ns/1ps
module prntv_sink (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // test word side
    input  wire logic [31:0] streams,
    input  wire logic        valid,
    input  wire logic        first,
    output logic             ready,
    // stall control and report
    input  wire logic        hold,
    output logic             got,
    output logic      [31:0] got_word,
    output logic             got_first
);
    assign ready = ~hold;
    // one-cycle report of each accepted word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            got       <= 1'b0;
            got_word  <= 32'hffffffff;
            got_first <= 1'b0;
        end else begin
            got       <= valid & ready;
            got_word  <= streams;
            got_first <= first;
        end
    end
endmodule

/* File: tb/tb_prn_test_vector_gen_check.sv */
// self-checking bench for the test stream generator and checker
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin cmp_count++; if ((ex) !== (sn)) begin \
    bad_count++; $display("mismatch %s expected %h seen %h", nm, ex, sn); \
    end end
module tb_prn_test_vector_gen_check;
    logic        REF_CLK = 0, RST = 1, GEN_ENABLE = 0, REPLAY_SECOND_TICK = 0;
    logic [1:0]  GEN_MODE = 2'h0;
    logic [2:0]  RATE_LOG2 = 3'h0;
    logic        ACQUIRE_SECOND_TICK = 0, RX_VALID = 0, hold = 0, stall_on = 0;
    logic [31:0] RX_STREAMS = 32'h0, TEST_STREAMS, ERR_COUNT, BITS_CHECKED;
    logic [4:0]  ERR_SEL = 5'h0;
    logic        TX_READY, TX_VALID, TX_FIRST, CHECK_ARMED;
    logic        got, got_first, skip = 1;
    logic [31:0] got_word, e, seedw, exp_err[32], xs = 32'd34044;
    logic [14:0] s[32], r[32];
    logic [1:0]  emode = 2'h0;
    int          bad_count = 0, cmp_count = 0, widx = 0, n_first = 0;
    int          n_tick = 0, c;
    always #5 REF_CLK = ~REF_CLK;
    prntv_top dut (.REF_CLK(REF_CLK), .RST(RST), .GEN_ENABLE(GEN_ENABLE),
        .GEN_MODE(GEN_MODE), .RATE_LOG2(RATE_LOG2),
        .REPLAY_SECOND_TICK(REPLAY_SECOND_TICK), .TX_READY(TX_READY),
        .TEST_STREAMS(TEST_STREAMS), .TX_VALID(TX_VALID), .TX_FIRST(TX_FIRST),
        .ACQUIRE_SECOND_TICK(ACQUIRE_SECOND_TICK), .RX_STREAMS(RX_STREAMS),
        .RX_VALID(RX_VALID), .ERR_SEL(ERR_SEL), .ERR_COUNT(ERR_COUNT),
        .BITS_CHECKED(BITS_CHECKED), .CHECK_ARMED(CHECK_ARMED));
    prntv_sink sink (.clk(REF_CLK), .rst(RST), .streams(TEST_STREAMS),
        .valid(TX_VALID), .first(TX_FIRST), .ready(TX_READY), .hold(hold),
        .got(got), .got_word(got_word), .got_first(got_first));
    // ---------------------------------------------------------------
    // reference functions
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction
    function automatic logic [14:0] nxt(logic [14:0] v);
        return {v[13:0], v[14] ^ v[13]};
    endfunction
    function automatic logic [14:0] seed(int i);
        return {i[4:0], 10'h2a5};
    endfunction
    // ---------------------------------------------------------------
    // monitor of generated words
    // ---------------------------------------------------------------
    always @(negedge REF_CLK) begin
        hold <= stall_on ? (rnd() % 4 == 0) : 1'b0;
        if (TX_VALID === 1'b0) `CHK("idle", 32'hffffffff, TEST_STREAMS)
        if (got === 1'b1) begin
            if (got_first === 1'b1) begin
                skip = 0;
                widx = 0;
                n_first++;
                emode = GEN_MODE;
                for (int i = 0; i < 32; i++) s[i] = seed(i);
            end
            if (!skip) begin
                for (int i = 0; i < 32; i++) e[i] = s[i][14];
                if (emode == 2'h1) e = 32'h0;
                if (emode == 2'h3) e = 32'hffffffff;
                `CHK("word", e, got_word)
                if (widx == 32767) `CHK("wrap", seedw, got_word)
                for (int i = 0; i < 32; i++) s[i] = nxt(s[i]);
                widx++;
            end
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic pulse(input bit acq);
        @(negedge REF_CLK);
        if (acq) ACQUIRE_SECOND_TICK = 1;
        else REPLAY_SECOND_TICK = 1;
        if (!acq && GEN_ENABLE) n_tick++;
        @(negedge REF_CLK);
        ACQUIRE_SECOND_TICK = 0;
        REPLAY_SECOND_TICK = 0;
    endtask
    // acquisition side: replica stream with sparse bit errors
    task automatic rx_run(input int n, input bit konst);
        logic [31:0] w, m;
        int          sent;
        sent = 0;
        for (int i = 0; i < 32; i++) begin
            r[i] = seed(i);
            exp_err[i] = 32'h0;
        end
        pulse(1);
        while (sent < n) begin
            if (rnd() % 4 != 0) begin
                for (int i = 0; i < 32; i++) m[i] = r[i][14];
                w = konst ? 32'hffffffff : m ^ (rnd() & rnd() & rnd());
                for (int i = 0; i < 32; i++) begin
                    exp_err[i] += 32'(w[i] != m[i]);
                    r[i] = nxt(r[i]);
                end
                RX_STREAMS = w;
                RX_VALID = 1;
                sent++;
            end else begin
                RX_VALID = 0;
                RX_STREAMS = rnd();
            end
            @(negedge REF_CLK);
        end
        RX_VALID = 0;
        repeat (3) @(negedge REF_CLK);
        `CHK("bits", 32'(n), BITS_CHECKED)
        `CHK("armed", 1'b1, CHECK_ARMED)
        for (int i = 0; i < 32; i++) begin
            ERR_SEL = 5'(i);
            repeat (2) @(negedge REF_CLK);
            `CHK("errs", exp_err[i], ERR_COUNT)
            if (konst) `CHK("half", 1'b1, ERR_COUNT > n / 4 && ERR_COUNT < 3 * n / 4)
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #900000;
        bad_count++;
        give_verdict();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        for (int i = 0; i < 32; i++) begin
            s[i] = seed(i);
            seedw[i] = s[i][14];
        end
        repeat (16) @(negedge REF_CLK);
        `CHK("rst_valid", 1'b0, TX_VALID)
        `CHK("rst_armed", 1'b0, CHECK_ARMED)
        RST = 0;
        RX_VALID = 1;
        repeat (5) @(negedge REF_CLK);
        RX_VALID = 0;
        repeat (2) @(negedge REF_CLK);
        `CHK("unarmed", 32'h0, BITS_CHECKED)
        rx_run(300, 0);
        rx_run(400, 1);
        pulse(0);
        repeat (20) @(negedge REF_CLK);
        `CHK("no_enable", 1'b0, TX_VALID)
        GEN_ENABLE = 1;
        stall_on = 1;
        pulse(0);
        while (widx < 32770) @(negedge REF_CLK);
        for (int k = 0; k < 4; k++) begin
            skip = 1;
            GEN_MODE = (k == 3) ? 2'h2 : 2'(k == 2 ? 3 : k);
            pulse(0);
            repeat (60) @(negedge REF_CLK);
        end
        stall_on = 0;
        GEN_MODE = 2'h0;
        for (int k = 0; k < 8; k++) begin
            RATE_LOG2 = 3'(k);
            pulse(0);
            c = 1;
            while (!(TX_VALID === 1'b1 && TX_FIRST === 1'b1) && c < 400) begin
                @(negedge REF_CLK);
                c++;
            end
            `CHK("lead", 1'b1, c >= (1 << k) + 1 && c <= (1 << k) + 2)
            while (!(got === 1'b1 && got_first === 1'b1) && c < 800) begin
                @(negedge REF_CLK);
                c++;
            end
            c = 0;
            do begin
                @(negedge REF_CLK);
                c++;
            end while (got !== 1'b1 && c < 400);
            `CHK("spacing", 32'(1 << k), 32'(c))
        end
        repeat (300) @(negedge REF_CLK);
        `CHK("firsts", 32'(n_tick), 32'(n_first))
        RST = 1;
        @(negedge REF_CLK);
        `CHK("rerst_valid", 1'b0, TX_VALID)
        `CHK("rerst_bits", 32'h0, BITS_CHECKED)
        RST = 0;
        give_verdict();
    end
endmodule
